/* rtl/cssb_defs.svh */
/*
 * Bit positions, reset values and sizes for the two-slot card status and byte-select block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef CSSB_DEFS_SVH
`define CSSB_DEFS_SVH

`define CSSB_SLOTS        2
`define CSSB_EV_W         4
`define CSSB_EV_DEAD      0
`define CSSB_EV_WEAK      1
`define CSSB_EV_DETECT    2
`define CSSB_EV_ALERT     3
`define CSSB_PIN_W        4
`define CSSB_PIN_LINE1    0
`define CSSB_PIN_LINE2    1
`define CSSB_PIN_DET1     2
`define CSSB_PIN_DET2     3
`define CSSB_EV_RST       4'h0
`define CSSB_PIN_RST      4'hf

`endif

/* rtl/cssb_pkg.sv */
/*
 * Types shared by the card status and byte-select block.
 * Assumes cssb_defs.svh is on the include path.
 */
package cssb_pkg;
	`include "cssb_defs.svh"

	typedef enum logic [1:0] {
		CSSB_BATT_GOOD,
		CSSB_BATT_WEAK,
		CSSB_BATT_DEAD
	} cssb_batt_t;
endpackage

/* rtl/cssb_slot.sv */
/*
 * One card slot: battery decode, insertion detect, status events, byte selects and I/O read strobe.
 * Assumes card pins and host requests are synchronous to clk.
 */
`timescale 1ns/1ps
`include "cssb_defs.svh"
module cssb_slot
	import cssb_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   ce,
	// Socket configuration
	input  wire logic                   io_mode,
	input  wire logic                   ring_mode,
	input  wire logic                   audio_en,
	input  wire logic [`CSSB_EV_W-1:0]  evt_en,
	input  wire logic [`CSSB_EV_W-1:0]  evt_clr,
	// Host access request
	input  wire logic                   acc_req,
	input  wire logic                   acc_addr0,
	input  wire logic                   acc_wide,
	input  wire logic                   acc_io_rd,
	// Card pins
	input  wire logic                   battery_level_line_one,
	input  wire logic                   battery_level_line_two,
	input  wire logic                   insert_detect_one_n,
	input  wire logic                   insert_detect_two_n,
	input  wire logic                   io_read_ack_n,
	output logic                        even_byte_select_n,
	output logic                        odd_byte_select_n,
	output logic                        io_read_strobe_n,
	// Status
	output cssb_batt_t                  batt_state,
	output logic                        card_inserted,
	output logic [`CSSB_PIN_W-1:0]      pin_status,
	output logic [`CSSB_EV_W-1:0]       evt_pend,
	output logic                        phone_alert_in,
	output logic                        audio_bit,
	output logic                        io_rd_acked
);
	cssb_batt_t                 batt_q, batt_d;
	logic                       ins_q;
	logic [`CSSB_PIN_W-1:0]     pin_q;
	logic [`CSSB_EV_W-1:0]      pend_q, evt_set;
	logic                       even_q, odd_q, io_read_strobe_q, ack_q, ring_q;
	wire                        ins_d    = !insert_detect_one_n && !insert_detect_two_n;
	wire                        even_d   = acc_req && (acc_wide || !acc_addr0);
	wire                        odd_d    = acc_req && (acc_wide || acc_addr0);
	wire                        io_read_strobe_d   = acc_req && acc_io_rd;
	wire                        alert_on = io_mode && !ring_mode;

	// Line one low always means data lost; line two only matters while line one is high
	assign batt_d = !battery_level_line_one ? CSSB_BATT_DEAD :
		(!battery_level_line_two ? CSSB_BATT_WEAK : CSSB_BATT_GOOD);

	// Battery events only make sense for memory cards; in I/O mode line one is the alert
	assign evt_set[`CSSB_EV_DEAD]   = !io_mode && batt_d == CSSB_BATT_DEAD && batt_q != CSSB_BATT_DEAD;
	assign evt_set[`CSSB_EV_WEAK]   = !io_mode && batt_d == CSSB_BATT_WEAK && batt_q == CSSB_BATT_GOOD;
	assign evt_set[`CSSB_EV_DETECT] = ins_d != ins_q;
	assign evt_set[`CSSB_EV_ALERT]  = alert_on && pin_q[`CSSB_PIN_LINE1] && !battery_level_line_one;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			batt_q <= CSSB_BATT_GOOD;
			ins_q  <= 1'b0;
			pin_q  <= `CSSB_PIN_RST;
			pend_q <= `CSSB_EV_RST;
		end else if (ce) begin
			batt_q <= batt_d;
			ins_q  <= ins_d;
			pin_q  <= {insert_detect_two_n, insert_detect_one_n, battery_level_line_two, battery_level_line_one};
			// Set wins over clear so an event in the clearing cycle survives
			pend_q <= (pend_q & ~evt_clr) | (evt_set & evt_en);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			even_q <= 1'b0;
			odd_q  <= 1'b0;
			io_read_strobe_q <= 1'b0;
			ack_q  <= 1'b0;
			ring_q <= 1'b0;
		end else if (ce) begin
			even_q <= even_d;
			odd_q  <= odd_d;
			io_read_strobe_q <= io_read_strobe_d;
			ack_q  <= io_read_strobe_q && !io_read_ack_n;
			ring_q <= io_mode && ring_mode && !battery_level_line_one;
		end
	end

	assign even_byte_select_n = !even_q;
	assign odd_byte_select_n  = !odd_q;
	assign io_read_strobe_n   = !io_read_strobe_q;
	assign batt_state         = batt_q;
	assign card_inserted      = ins_q;
	assign pin_status         = pin_q;
	assign evt_pend           = pend_q;
	assign phone_alert_in     = ring_q;
	assign io_rd_acked        = ack_q;
	// Line two is audio only in I/O mode; a disabled slot adds a low level to the merge
	assign audio_bit          = io_mode && audio_en && battery_level_line_two;
endmodule

/* rtl/cssb_top.sv */
/*
 * Two-slot card status, insertion detect, byte-select and merged audio block.
 * Assumes all inputs are synchronous to clk; slot A is index 0, slot B index 1.
 */
`timescale 1ns/1ps
`include "cssb_defs.svh"
// Functional notes
// - Battery good when both high, weak when line two low, dead when line one low.
// - Battery signals readable as status and raise change events gated by enables; the code raises them only outside I/O mode, on weak from good or on dead.
// - Line two is audio only in I/O mode, ignored otherwise.
// - Audio of both slots merges onto one output pin.
// - Card inserted when both detect lines low; levels reported as status.
// - First byte select enables even-addressed bytes.
// - Second byte select enables odd-addressed bytes.
// - I/O read strobe asserted to enable card data during host I/O reads.
module cssb_top
	import cssb_pkg::*;
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic                       ce,
	// Per-slot configuration
	input  wire logic [1:0]                 io_mode,
	input  wire logic [1:0]                 ring_mode,
	input  wire logic [1:0]                 audio_en,
	input  wire logic [`CSSB_EV_W-1:0]      evt_en_a,
	input  wire logic [`CSSB_EV_W-1:0]      evt_en_b,
	input  wire logic [`CSSB_EV_W-1:0]      evt_clr_a,
	input  wire logic [`CSSB_EV_W-1:0]      evt_clr_b,
	// Per-slot host access
	input  wire logic [1:0]                 acc_req,
	input  wire logic [1:0]                 acc_addr0,
	input  wire logic [1:0]                 acc_wide,
	input  wire logic [1:0]                 acc_io_rd,
	// Card pins
	input  wire logic [1:0]                 battery_level_line_one,
	input  wire logic [1:0]                 battery_level_line_two,
	input  wire logic [1:0]                 insert_detect_one_n,
	input  wire logic [1:0]                 insert_detect_two_n,
	input  wire logic [1:0]                 io_read_ack_n,
	output logic [1:0]                      even_byte_select_n,
	output logic [1:0]                      odd_byte_select_n,
	output logic [1:0]                      io_read_strobe_n,
	output logic                            merged_audio_out,
	// Status
	output cssb_batt_t [1:0]                batt_state,
	output logic [1:0]                      card_inserted,
	output logic [`CSSB_PIN_W-1:0]          pin_status_a,
	output logic [`CSSB_PIN_W-1:0]          pin_status_b,
	output logic [`CSSB_EV_W-1:0]           evt_pend_a,
	output logic [`CSSB_EV_W-1:0]           evt_pend_b,
	output logic [1:0]                      phone_alert_in,
	output logic [1:0]                      io_rd_acked
);
	logic [1:0]                 audio_bit;
	logic                       audio_q;
	wire  [`CSSB_EV_W-1:0]      evt_en  [2];
	wire  [`CSSB_EV_W-1:0]      evt_clr [2];
	wire  [`CSSB_PIN_W-1:0]     pin_st  [2];
	wire  [`CSSB_EV_W-1:0]      pend    [2];

	assign evt_en[0]    = evt_en_a;
	assign evt_en[1]    = evt_en_b;
	assign evt_clr[0]   = evt_clr_a;
	assign evt_clr[1]   = evt_clr_b;
	assign pin_status_a = pin_st[0];
	assign pin_status_b = pin_st[1];
	assign evt_pend_a   = pend[0];
	assign evt_pend_b   = pend[1];

	genvar s;
	generate
		for (s = 0; s < `CSSB_SLOTS; s++) begin : g_slot
			cssb_slot u_slot (
				.clk                    (clk),
				.rstn                   (rstn),
				.ce                     (ce),
				.io_mode                (io_mode[s]),
				.ring_mode              (ring_mode[s]),
				.audio_en               (audio_en[s]),
				.evt_en                 (evt_en[s]),
				.evt_clr                (evt_clr[s]),
				.acc_req                (acc_req[s]),
				.acc_addr0              (acc_addr0[s]),
				.acc_wide               (acc_wide[s]),
				.acc_io_rd              (acc_io_rd[s]),
				.battery_level_line_one (battery_level_line_one[s]),
				.battery_level_line_two (battery_level_line_two[s]),
				.insert_detect_one_n    (insert_detect_one_n[s]),
				.insert_detect_two_n    (insert_detect_two_n[s]),
				.io_read_ack_n          (io_read_ack_n[s]),
				.even_byte_select_n     (even_byte_select_n[s]),
				.odd_byte_select_n      (odd_byte_select_n[s]),
				.io_read_strobe_n       (io_read_strobe_n[s]),
				.batt_state             (batt_state[s]),
				.card_inserted          (card_inserted[s]),
				.pin_status             (pin_st[s]),
				.evt_pend               (pend[s]),
				.phone_alert_in         (phone_alert_in[s]),
				.audio_bit              (audio_bit[s]),
				.io_rd_acked            (io_rd_acked[s])
			);
		end
	endgenerate

	// XOR keeps a single active card audible and needs no arbitration between slots
	always_ff @(posedge clk) begin
		if (!rstn) begin
			audio_q <= 1'b0;
		end else if (ce) begin
			audio_q <= audio_bit[0] ^ audio_bit[1];
		end
	end

	assign merged_audio_out = audio_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	batt_dead_decode_a: assert property (ce && !battery_level_line_one[0] |=>
		batt_state[0] == CSSB_BATT_DEAD)
		else $error("slot A line one low did not decode as dead");

	batt_weak_decode_a: assert property (ce && battery_level_line_one[1] && !battery_level_line_two[1] |=>
		batt_state[1] == CSSB_BATT_WEAK)
		else $error("slot B weak battery not decoded");

	evt_gate_a: assert property ($rose(evt_pend_a[`CSSB_EV_DETECT]) |->
		$past(evt_en_a[`CSSB_EV_DETECT]) && $past(ce) && card_inserted[0] != $past(card_inserted[0]))
		else $error("detect event set without its enable");

	evt_sticky_a: assert property (evt_pend_a[`CSSB_EV_ALERT] && !evt_clr_a[`CSSB_EV_ALERT] |=>
		evt_pend_a[`CSSB_EV_ALERT])
		else $error("alert event lost without a clear");

	audio_ignore_a: assert property (ce && !io_mode[0] && !io_mode[1] |=> !merged_audio_out)
		else $error("audio output active with no slot in I/O mode");

	audio_merge_a: assert property (ce |=> merged_audio_out == $past(
		(io_mode[0] & audio_en[0] & battery_level_line_two[0]) ^
		(io_mode[1] & audio_en[1] & battery_level_line_two[1])))
		else $error("merged audio is not the XOR of enabled slots");

	insert_detect_a: assert property (ce && !insert_detect_one_n[0] && !insert_detect_two_n[0] |=>
		card_inserted[0] && !pin_status_a[`CSSB_PIN_DET1] && !pin_status_a[`CSSB_PIN_DET2])
		else $error("seated card not reported as inserted");

	even_select_a: assert property (ce && acc_req[0] && !acc_wide[0] && acc_addr0[0] |=>
		even_byte_select_n[0] && !odd_byte_select_n[0])
		else $error("odd byte access selected the even lane");

	odd_select_a: assert property (ce && acc_req[1] && acc_wide[1] |=>
		!even_byte_select_n[1] && !odd_byte_select_n[1])
		else $error("word access did not select both lanes");

	io_strobe_a: assert property ((ce && acc_req[0] && acc_io_rd[0]) ##1 (ce && !io_read_ack_n[0]) |=>
		io_rd_acked[0])
		else $error("acknowledged I/O read not captured");

	strobe_follow_a: assert property (ce && acc_req[0] && acc_io_rd[0] |=>
		!io_read_strobe_n[0])
		else $error("I/O read did not raise the strobe");

	strobe_idle_a: assert property (ce && !acc_req[1] |=>
		io_read_strobe_n[1])
		else $error("strobe active with no access");

	lane_idle_a: assert property (ce && !acc_req[1] |=>
		even_byte_select_n[1] && odd_byte_select_n[1])
		else $error("byte lane selected with no access");

	even_lane_a: assert property (ce && acc_req[0] && !acc_wide[0] && !acc_addr0[0] |=>
		!even_byte_select_n[0] && odd_byte_select_n[0])
		else $error("even byte access did not select only the even lane");

	// A frozen enable must hold every registered output, or software sees half-updated status
	frozen_hold_a: assert property (!ce |=>
		$stable(batt_state) && $stable(evt_pend_a) && $stable(io_read_strobe_n))
		else $error("state moved while the clock enable was low");

	// Event flags are registered, so each cause shows up one edge later
	alert_event_a: assert property (ce && io_mode[0] && !ring_mode[0] && evt_en_a[`CSSB_EV_ALERT] &&
		pin_status_a[`CSSB_PIN_LINE1] && !battery_level_line_one[0] |=> evt_pend_a[`CSSB_EV_ALERT])
		else $error("falling alert line did not raise its event");

	ring_level_a: assert property (ce |=>
		phone_alert_in[1] == $past(io_mode[1] && ring_mode[1] && !battery_level_line_one[1]))
		else $error("ring indication does not follow line one");

	dead_event_a: assert property (ce && !io_mode[0] && evt_en_a[`CSSB_EV_DEAD] &&
		!battery_level_line_one[0] && batt_state[0] != CSSB_BATT_DEAD |=> evt_pend_a[`CSSB_EV_DEAD])
		else $error("entering dead battery did not raise its event");

	weak_mask_a: assert property (ce && !evt_en_a[`CSSB_EV_WEAK] && !evt_pend_a[`CSSB_EV_WEAK] |=>
		!evt_pend_a[`CSSB_EV_WEAK])
		else $error("disabled weak event became pending");

	pin_levels_a: assert property (ce |=> pin_status_b ==
		$past({insert_detect_two_n[1], insert_detect_one_n[1], battery_level_line_two[1], battery_level_line_one[1]}))
		else $error("pin status does not report the card lines");

	card_removed_a: assert property (ce && (insert_detect_one_n[0] || insert_detect_two_n[0]) |=>
		!card_inserted[0])
		else $error("card reported inserted with a detect line high");

	good_decode_a: assert property (ce && battery_level_line_one[1] && battery_level_line_two[1] |=>
		batt_state[1] == CSSB_BATT_GOOD)
		else $error("both battery lines high did not decode as good");

	clear_event_a: assert property (ce && evt_clr_a[`CSSB_EV_DETECT] && !evt_en_a[`CSSB_EV_DETECT] |=>
		!evt_pend_a[`CSSB_EV_DETECT])
		else $error("detect event survived its clear");

	detect_event_a: assert property (ce && evt_en_a[`CSSB_EV_DETECT] &&
		card_inserted[0] == (insert_detect_one_n[0] || insert_detect_two_n[0]) |=> evt_pend_a[`CSSB_EV_DETECT])
		else $error("insertion change did not raise its event");

	cover_word_read_c: cover property (ce && acc_req[0] && acc_wide[0] && acc_io_rd[0] ##1 !io_read_strobe_n[0]);
	cover_insert_c: cover property ($rose(card_inserted[0]) ##1 evt_pend_a[`CSSB_EV_DETECT]);
	cover_alert_c: cover property (ce && evt_en_a[`CSSB_EV_ALERT] ##1 $rose(evt_pend_a[`CSSB_EV_ALERT]));
	cover_audio_c: cover property ($rose(merged_audio_out));
	cover_dead_c: cover property ($rose(evt_pend_a[`CSSB_EV_DEAD]));
endmodule

/* bench/cssb_card_model.sv */
/*
 * Behavioural card for one slot: battery lines, detect lines and input acknowledge.
 * Assumes the bench sets its behaviour between clock edges.
 */
`timescale 1ns/1ps
module cssb_card_model (
	// Clock
	input  wire logic clk,
	// Behaviour chosen by the bench
	input  wire logic seated,
	input  wire logic batt_one,
	input  wire logic batt_two,
	input  wire logic can_ack,
	input  wire logic slow,
	// Socket pins
	input  wire logic io_read_strobe_n,
	output logic      battery_level_line_one,
	output logic      battery_level_line_two,
	output logic      insert_detect_one_n,
	output logic      insert_detect_two_n,
	output logic      io_read_ack_n,
	output logic      ready
);
	logic ack_q = 1'b1;
	always @(posedge clk) begin
		ack_q <= io_read_strobe_n | ~can_ack;
	end
	// Host pull-ups hold the lines of an empty slot high
	assign battery_level_line_one = seated ? batt_one : 1'b1;
	assign battery_level_line_two = seated ? batt_two : 1'b1;
	assign insert_detect_one_n    = ~seated;
	assign insert_detect_two_n    = ~seated;
	// A slow card answers one cycle after it sees the strobe
	assign io_read_ack_n = io_read_strobe_n | ~can_ack | (slow & ack_q);
	// This block never issues writes, so the card is never busy and ready stays high
	assign ready = 1'b1;
endmodule

/* bench/card_slot_status_and_byte_select_tb.sv */
/*
 * Self-checking bench for the two-slot status and byte-select block.
 * Assumes the design packages are compiled first; one card model per slot.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module card_slot_status_and_byte_select_tb
	import cssb_pkg::*;
;
	typedef struct packed {
		logic [1:0] io, aen, l1, l2;
		logic       req, a0, wide;
		logic [3:0] eb;
		logic       aud;
		logic [1:0] ev, od;
	} cssb_row_t;
	localparam cssb_row_t ROWS [9] = '{
		'{2'h0, 2'h0, 2'h3, 2'h3, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 2'h0, 2'h3},
		'{2'h0, 2'h3, 2'h3, 2'h2, 1'b1, 1'b1, 1'b0, 4'h1, 1'b0, 2'h3, 2'h0},
		'{2'h0, 2'h0, 2'h2, 2'h1, 1'b1, 1'b0, 1'b1, 4'h6, 1'b0, 2'h0, 2'h0},
		'{2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 4'ha, 1'b0, 2'h3, 2'h3},
		'{2'h3, 2'h3, 2'h3, 2'h1, 1'b1, 1'b1, 1'b1, 4'h4, 1'b1, 2'h0, 2'h0},
		'{2'h3, 2'h3, 2'h3, 2'h3, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0, 2'h3, 2'h3},
		'{2'h3, 2'h1, 2'h3, 2'h3, 1'b1, 1'b1, 1'b0, 4'h0, 1'b1, 2'h3, 2'h0},
		'{2'h1, 2'h3, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 4'h1, 1'b0, 2'h0, 2'h3},
		'{2'h2, 2'h3, 2'h3, 2'h2, 1'b0, 1'b0, 1'b0, 4'h1, 1'b1, 2'h3, 2'h3}};
	logic             clk, rstn, ce;
	logic [1:0]       io_mode, audio_en, acc_req, acc_addr0, acc_wide, acc_io_rd;
	logic [1:0]       l1, l2, seated, can_ack, slow, ring_mode;
	logic [3:0]       evt_en_a, evt_clr_a;
	wire  [1:0]       bl1, bl2, det1_n, det2_n, ack_n, even_n, odd_n, strobe_n, ins, acked, ring;
	wire              aud;
	cssb_batt_t [1:0] batt;
	wire  [3:0]       pin_a, pend_a, pend_b;
	int               fails, cmp_count;

	// Slot B shares slot A's event controls, so its flags must stay quiet unless it sees a cause
	cssb_top u_dut (.clk(clk), .rstn(rstn), .ce(ce), .io_mode(io_mode), .ring_mode(ring_mode),
		.audio_en(audio_en), .evt_en_a(evt_en_a), .evt_en_b(evt_en_a), .evt_clr_a(evt_clr_a),
		.evt_clr_b(evt_clr_a), .acc_req(acc_req), .acc_addr0(acc_addr0), .acc_wide(acc_wide),
		.acc_io_rd(acc_io_rd), .battery_level_line_one(bl1), .battery_level_line_two(bl2),
		.insert_detect_one_n(det1_n), .insert_detect_two_n(det2_n), .io_read_ack_n(ack_n),
		.even_byte_select_n(even_n), .odd_byte_select_n(odd_n), .io_read_strobe_n(strobe_n),
		.merged_audio_out(aud), .batt_state(batt), .card_inserted(ins), .pin_status_a(pin_a),
		.pin_status_b(), .evt_pend_a(pend_a), .evt_pend_b(pend_b), .phone_alert_in(ring), .io_rd_acked(acked));
	for (genvar i = 0; i < 2; i++) begin : g_card
		cssb_card_model u_card (.clk(clk), .seated(seated[i]), .batt_one(l1[i]), .batt_two(l2[i]),
			.can_ack(can_ack[i]), .slow(slow[i]), .io_read_strobe_n(strobe_n[i]),
			.battery_level_line_one(bl1[i]), .battery_level_line_two(bl2[i]),
			.insert_detect_one_n(det1_n[i]), .insert_detect_two_n(det2_n[i]),
			.io_read_ack_n(ack_n[i]), .ready());
	end

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Every step below has a fixed latency, so a hang only shows here
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		$display("MISMATCH watchdog exp 0 got 1");
		finish_test();
	end
	initial begin
		// Requests held active during reset must not reach the pins
		{rstn, ce, io_mode, audio_en, acc_req, acc_addr0, acc_wide, acc_io_rd} = 14'h1fd7;
		{l1, l2, seated, can_ack, slow, evt_en_a, evt_clr_a} = 18'h0fc00;
		ring_mode = 2'h0;
		repeat (4) tick();
		`CHK("reset even", 2'h3, even_n)
		`CHK("reset strobe", 2'h3, strobe_n)
		`CHK("reset audio", 1'b0, aud)
		`CHK("reset state", 4'h0, batt)
		`CHK("reset pins", 4'hf, pin_a)
		`CHK("reset flags", 4'h0, pend_a)
		$display("test reset done");
		rstn = 1'b1;
		acc_io_rd = 2'h0;
		for (int i = 0; i < 9; i++) begin
			{io_mode, audio_en, l1, l2} = {ROWS[i].io, ROWS[i].aen, ROWS[i].l1, ROWS[i].l2};
			{acc_req, acc_addr0, acc_wide} = {{2{ROWS[i].req}}, {2{ROWS[i].a0}}, {2{ROWS[i].wide}}};
			tick();
			`CHK("state", ROWS[i].eb, batt)
			`CHK("audio", ROWS[i].aud, aud)
			`CHK("even", ROWS[i].ev, even_n)
			`CHK("odd", ROWS[i].od, odd_n)
		end
		$display("test table done");
		{io_mode, l1, l2, acc_req, evt_en_a} = 12'h3c1;
		tick();
		l2 = 2'h2;
		tick();
		`CHK("weak masked", 4'h0, pend_a)
		l1 = 2'h2;
		tick();
		`CHK("dead flag", 4'h1, pend_a)
		evt_clr_a = 4'h1;
		tick();
		`CHK("dead clear", 4'h0, pend_a)
		{evt_clr_a, evt_en_a, seated} = 10'h012;
		tick();
		`CHK("removed", 2'h2, ins)
		`CHK("empty pins", 4'hf, pin_a)
		`CHK("detect flag", 4'h4, pend_a)
		{evt_clr_a, seated} = 6'h13;
		tick();
		evt_clr_a = 4'h0;
		tick();
		`CHK("inserted", 2'h3, ins)
		`CHK("seated pins", 4'h0, pin_a)
		`CHK("detect again", 4'h4, pend_a)
		$display("test events done");
		{evt_en_a, acc_req, acc_io_rd, can_ack} = 10'h015;
		tick();
		`CHK("strobe", 2'h2, strobe_n)
		tick();
		`CHK("prompt ack", 2'h1, acked)
		{acc_req, slow} = 4'h1;
		tick();
		acc_req = 2'h1;
		tick();
		tick();
		`CHK("slow wait", 2'h0, acked)
		tick();
		`CHK("slow ack", 2'h1, acked)
		can_ack = 2'h0;
		tick();
		tick();
		`CHK("no ack", 2'h0, acked)
		$display("test read done");
		{acc_req, acc_io_rd, acc_wide} = 6'h03;
		tick();
		{ce, acc_req} = 3'h3;
		tick();
		`CHK("frozen", 2'h3, even_n)
		ce = 1'b1;
		tick();
		`CHK("wide", 2'h0, even_n | odd_n)
		$display("test freeze done");
		// Slot A raises the alert event, slot B is in the ring role
		{io_mode, ring_mode, l1, evt_en_a, evt_clr_a} = 14'h3b84;
		tick();
		`CHK("alert idle", 4'h0, pend_a)
		{l1, evt_clr_a} = 6'h00;
		tick();
		`CHK("alert flag", 4'h8, pend_a)
		`CHK("ring level", 2'h2, ring)
		tick();
		`CHK("alert held", 4'h8, pend_a)
		`CHK("slot b quiet", 4'h0, pend_b)
		evt_clr_a = 4'h8;
		tick();
		`CHK("alert clear", 4'h0, pend_a)
		$display("test alert done");
		// Reset in mid-run with the enable low must still clear everything
		{rstn, ce, evt_en_a, evt_clr_a} = 10'h000;
		tick();
		`CHK("reset again", 2'h3, even_n & strobe_n)
		`CHK("reset ring", 2'h0, ring)
		`CHK("reset inserted", 2'h0, ins)
		{rstn, ce} = 2'h3;
		tick();
		`CHK("back inserted", 2'h3, ins)
		`CHK("back lanes", 2'h0, even_n | odd_n)
		`CHK("back flags", 4'h0, pend_a)
		$display("test reset again done");
		finish_test();
	end
endmodule
